/* File: rims_monitor_select.sv */
// Redundant reference input monitor, input selection with holdover, and register port
//
// Notes on behaviour
// - Input declared lost after three consecutive missing edges per monitor period.
// - Each input has its own detector and 5-bit monitor divider on VCXO ticks.
// - In differential mode a zero differential voltage also flags loss.
// - Loss shows as a live status bit and a sticky latched bit.
// - Loss events can drive the active-low interrupt output.
// - Detection works only with the VCXO-PLL not bypassed.
// - Only missing edges are detected, never wrong frequency.
// - Lost input revalidated after programmable consecutive good periods.
// - Five selection modes from holdover-disable and two mode bits.
// - Manual modes follow pin or internal bit per source select, never a machine.
// - Loss on the primary input keeps it selected without holdover.
// - Holdover mode: manual change enters holdover and starts hold-off down-counter.
// - Primary is the selected input, secondary the other.
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "rims_regs.svh"

module rims_monitor_select
(
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [31:0] regRdata,
    input  wire logic        vcxoClk,
    input  wire logic [1:0]  refClkPin,
    input  wire logic [1:0]  diffZeroPin,
    input  wire logic        select_pin,
    output logic             pllRefSelect,
    output logic             holdover_active_n,
    output logic             irq_out_n
);

    // =========================================================
    // Registers and synchronisers
    // =========================================================
    rims_pkg::rims_ctrl_t      ctrl;
    rims_pkg::rims_sel_state_t selState;
    logic [4:0]  monitor_divider [2];
    logic [7:0]  revalidate_count;
    logic [15:0] holdoff_count;
    logic [15:0] holdoff_prescale;
    logic [1:0]  irqMask;
    logic [1:0]  input_loss_latched;
    logic [1:0]  input_loss_live;
    logic [1:0]  vcxoSync;
    logic        vcxoPrev;
    logic [1:0]  selPinSync;
    logic [15:0] holdCnt;
    logic [15:0] preCnt;
    logic        reference_loss_flag;

    function automatic rims_pkg::rims_mode_t modeOf(input rims_pkg::rims_ctrl_t c);
        if (!c.holdoverDisable)
            modeOf = rims_pkg::MODE_HOLDOVER;
        else
        begin
            unique case ({c.selectModeHi, c.selectModeLo})
                2'b00: modeOf = rims_pkg::MODE_MANUAL;
                2'b01: modeOf = rims_pkg::MODE_AUTO_A;
                2'b10: modeOf = rims_pkg::MODE_AUTO_B;
                2'b11: modeOf = rims_pkg::MODE_SHORT_HOLD;
            endcase
        end
    endfunction

    // =========================================================
    // Decoding
    // =========================================================
    wire rims_pkg::rims_mode_t mode = modeOf(ctrl);
    wire holdoverMode = (mode == rims_pkg::MODE_HOLDOVER);
    // The VCXO must run below half of sys_clk for edge sampling to see every cycle
    wire vcxoTick     = vcxoSync[1] & ~vcxoPrev;
    wire requestedSel = ctrl.srcInternal ? ctrl.intSel : selPinSync[1];
    wire wrCtrl       = regWrite && regAddr == `RIMS_ADDR_CTRL;
    wire wrMonDiv     = regWrite && regAddr == `RIMS_ADDR_MONDIV;
    wire wrReval      = regWrite && regAddr == `RIMS_ADDR_REVAL;
    wire wrHoldoff    = regWrite && regAddr == `RIMS_ADDR_HOLDOFF;
    wire wrPrescale   = regWrite && regAddr == `RIMS_ADDR_PRESCALE;
    wire wrStatus     = regWrite && regAddr == `RIMS_ADDR_STATUS;
    wire wrMask       = regWrite && regAddr == `RIMS_ADDR_MASK;
    wire [1:0] latchClear = wrStatus ? regWdata[`RIMS_ST_LATCH_LSB +: 2] : 2'h0;
    wire [15:0] preLast = (holdoff_prescale == 16'h0000) ? 16'h0000
                                                         : holdoff_prescale - 16'h0001;
    wire inHold   = (selState == rims_pkg::SEL_HOLD);
    wire preTick  = inHold & vcxoTick & (preCnt == preLast);
    wire expire   = inHold & ((holdCnt == 16'h0000) | (preTick & holdCnt == 16'h0001));
    wire changeRq = !inHold && (requestedSel != pllRefSelect);

    rims_pkg::rims_status_t status;
    assign status.referenceLossFlag = reference_loss_flag;
    assign status.selectedInputFlag = pllRefSelect;
    assign status.holdoverActiveN   = holdover_active_n;
    assign status.inputLossLatched  = input_loss_latched;
    assign status.inputLossLive     = input_loss_live;

    wire [31:0] readMux =
        (regAddr == `RIMS_ADDR_CTRL)     ? {24'h00_0000, ctrl} :
        (regAddr == `RIMS_ADDR_MONDIV)   ? {19'h0_0000, monitor_divider[1], 3'h0,
                                            monitor_divider[0]} :
        (regAddr == `RIMS_ADDR_REVAL)    ? {24'h00_0000, revalidate_count} :
        (regAddr == `RIMS_ADDR_HOLDOFF)  ? {16'h0000, holdoff_count} :
        (regAddr == `RIMS_ADDR_PRESCALE) ? {16'h0000, holdoff_prescale} :
        (regAddr == `RIMS_ADDR_STATUS)   ? {25'h000_0000, status} :
        (regAddr == `RIMS_ADDR_MASK)     ? {30'h0000_0000, irqMask} :
                                           32'h0000_0000;

    always_ff @(posedge sys_clk)
    begin
        vcxoSync   <= {vcxoSync[0], vcxoClk};
        vcxoPrev   <= vcxoSync[1];
        selPinSync <= {selPinSync[0], select_pin};
    end

    // =========================================================
    // Register port
    // =========================================================
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            ctrl             <= `RIMS_CTRL_RESET;
            revalidate_count <= `RIMS_REVAL_RESET;
            holdoff_count    <= `RIMS_HOLDOFF_RESET;
            holdoff_prescale <= `RIMS_PRESCALE_RESET;
            irqMask          <= `RIMS_MASK_RESET;
        end
        else
        begin
            if (wrCtrl)
                ctrl <= regWdata[7:0];
            if (wrReval)
                revalidate_count <= regWdata[7:0];
            if (wrHoldoff)
                holdoff_count <= regWdata[15:0];
            if (wrPrescale)
                holdoff_prescale <= regWdata[15:0];
            if (wrMask)
                irqMask <= regWdata[1:0];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            regRdata <= 32'h0000_0000;
        else
            regRdata <= regRead ? readMux : 32'h0000_0000;
    end

    // =========================================================
    // Per-input detectors
    // =========================================================
    for (genvar i = 0; i < 2; i++)
    begin : g_input
        localparam int LSB = (i == 0) ? `RIMS_MONDIV0_LSB : `RIMS_MONDIV1_LSB;

        always_ff @(posedge sys_clk)
        begin
            if (!rst_b)
                monitor_divider[i] <= `RIMS_MONDIV_RESET;
            else if (wrMonDiv)
                monitor_divider[i] <= regWdata[LSB +: 5];
        end

        rims_los_detect u_detect
        (
            .sys_clk         (sys_clk),
            .rst_b           (rst_b),
            .enable          (!ctrl.vcxoPllBypass),
            .vcxoTick        (vcxoTick),
            .monitorDivider  (monitor_divider[i]),
            .revalidateCount (revalidate_count),
            .diffMode        (i == 0 ? ctrl.diffMode0 : ctrl.diffMode1),
            .clkPin          (refClkPin[i]),
            .diffZeroPin     (diffZeroPin[i]),
            .lossLive        (input_loss_live[i])
        );

        // Set beats clear so a loss in the clearing cycle is never lost
        always_ff @(posedge sys_clk)
        begin
            if (!rst_b)
                input_loss_latched[i] <= 1'b0;
            else
                input_loss_latched[i] <= input_loss_live[i] |
                                         (input_loss_latched[i] & ~latchClear[i]);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            irq_out_n <= 1'b1;
        else
            irq_out_n <= ~|(input_loss_latched & irqMask);
    end

    // =========================================================
    // Input selection and holdover
    // =========================================================
    // Automatic and short-holdover modes behave as manual without holdover here
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            selState     <= rims_pkg::SEL_TRACK;
            pllRefSelect <= 1'b0;
        end
        else
        begin
            unique case (selState)
                rims_pkg::SEL_TRACK:
                begin
                    if (changeRq && holdoverMode)
                        selState <= rims_pkg::SEL_HOLD;
                    else if (changeRq)
                        pllRefSelect <= requestedSel;
                end
                rims_pkg::SEL_HOLD:
                begin
                    if (expire)
                    begin
                        selState     <= rims_pkg::SEL_TRACK;
                        pllRefSelect <= requestedSel;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b || !inHold)
            preCnt <= 16'h0000;
        else if (vcxoTick)
            preCnt <= preTick ? 16'h0000 : preCnt + 16'h0001;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            holdCnt <= 16'h0000;
        else if (changeRq && holdoverMode)
            holdCnt <= holdoff_count;
        else if (preTick && holdCnt != 16'h0000)
            holdCnt <= holdCnt - 16'h0001;
    end

    // Primary is the selected input; its loss never forces a switch or holdover
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            holdover_active_n   <= 1'b1;
            reference_loss_flag <= 1'b0;
        end
        else
        begin
            holdover_active_n   <= !(inHold && !expire) && !(changeRq && holdoverMode);
            reference_loss_flag <= (mode != rims_pkg::MODE_MANUAL) &&
                                   input_loss_live[pllRefSelect];
        end
    end

    // =========================================================
    // Checks
    // =========================================================
    sequence s_hold_entry;
        changeRq && holdoverMode;
    endsequence

    sequence s_in_hold;
        !holdover_active_n && inHold;
    endsequence

    property p_hold_start;
        @(posedge sys_clk) disable iff (!rst_b)
        s_hold_entry |=> s_in_hold;
    endproperty
    a_hold_start: assert property (p_hold_start) else $error("no holdover on change");

    property p_manual_follow;
        @(posedge sys_clk) disable iff (!rst_b)
        (changeRq && !holdoverMode) |=> (pllRefSelect == $past(requestedSel)) && !inHold;
    endproperty
    a_manual_follow: assert property (p_manual_follow) else $error("manual not followed");

    property p_hold_keeps;
        @(posedge sys_clk) disable iff (!rst_b)
        (inHold && !expire) |=> $stable(pllRefSelect);
    endproperty
    a_hold_keeps: assert property (p_hold_keeps) else $error("switched during holdover");

    property p_expire_switch;
        @(posedge sys_clk) disable iff (!rst_b)
        expire |=> (pllRefSelect == $past(requestedSel)) && !inHold && holdover_active_n;
    endproperty
    a_expire_switch: assert property (p_expire_switch) else $error("expiry did not switch");

    property p_loss_no_switch;
        @(posedge sys_clk) disable iff (!rst_b)
        (!changeRq && !inHold && input_loss_live[pllRefSelect]) |=> $stable(pllRefSelect);
    endproperty
    a_loss_no_switch: assert property (p_loss_no_switch) else $error("loss moved select");

    property p_sticky;
        @(posedge sys_clk) disable iff (!rst_b)
        (input_loss_latched[0] && !latchClear[0]) |=> input_loss_latched[0];
    endproperty
    a_sticky: assert property (p_sticky) else $error("sticky bit dropped");

    property p_irq;
        @(posedge sys_clk) disable iff (!rst_b)
        (|(input_loss_live & irqMask)) |=> ##1 !irq_out_n;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    property p_bypass;
        @(posedge sys_clk) disable iff (!rst_b)
        ctrl.vcxoPllBypass [*2] |-> input_loss_live == 2'h0;
    endproperty
    a_bypass: assert property (p_bypass) else $error("loss flagged in bypass");

    property p_rdata_slot;
        @(posedge sys_clk) disable iff (!rst_b)
        !regRead |=> regRdata == 32'h0000_0000;
    endproperty
    a_rdata_slot: assert property (p_rdata_slot) else $error("read data outside slot");

endmodule
`default_nettype wire

/* File: rims_regs.svh */
// Register offsets, field positions, reset values and counts of the input monitor/selector
`ifndef RIMS_REGS_SVH
`define RIMS_REGS_SVH

`define RIMS_ADDR_CTRL        8'h00
`define RIMS_ADDR_MONDIV      8'h04
`define RIMS_ADDR_REVAL       8'h08
`define RIMS_ADDR_HOLDOFF     8'h0C
`define RIMS_ADDR_PRESCALE    8'h10
`define RIMS_ADDR_STATUS      8'h14
`define RIMS_ADDR_MASK        8'h18

`define RIMS_CTRL_BYPASS      0
`define RIMS_CTRL_HO_DIS      1
`define RIMS_CTRL_MODE_LO     2
`define RIMS_CTRL_MODE_HI     3
`define RIMS_CTRL_SRC_INT     4
`define RIMS_CTRL_INT_SEL     5
`define RIMS_CTRL_DIFF0       6
`define RIMS_CTRL_DIFF1       7

`define RIMS_MONDIV0_LSB      0
`define RIMS_MONDIV1_LSB      8

`define RIMS_ST_LIVE_LSB      0
`define RIMS_ST_LATCH_LSB     2
`define RIMS_ST_HOLD_N        4
`define RIMS_SELECTED_INPUT_FLAG           5
`define RIMS_ST_REFLOSS       6

`define RIMS_CTRL_RESET       8'h00
`define RIMS_MONDIV_RESET     5'h01
`define RIMS_REVAL_RESET      8'h04
`define RIMS_HOLDOFF_RESET    16'h0010
`define RIMS_PRESCALE_RESET   16'h0001
`define RIMS_MASK_RESET       2'h3

`define RIMS_MISS_LIMIT       2'h3

`endif

/* File: rims_pkg.sv */
// Types shared by the input monitor/selector files
`default_nettype none
package rims_pkg;

    typedef struct packed
    {
        logic diffMode1;
        logic diffMode0;
        logic intSel;
        logic srcInternal;
        logic selectModeHi;
        logic selectModeLo;
        logic holdoverDisable;
        logic vcxoPllBypass;
    } rims_ctrl_t;

    typedef struct packed
    {
        logic       referenceLossFlag;
        logic       selectedInputFlag;
        logic       holdoverActiveN;
        logic [1:0] inputLossLatched;
        logic [1:0] inputLossLive;
    } rims_status_t;

    typedef enum logic [2:0]
    {
        MODE_HOLDOVER,
        MODE_MANUAL,
        MODE_AUTO_A,
        MODE_AUTO_B,
        MODE_SHORT_HOLD
    } rims_mode_t;

    typedef enum logic
    {
        SEL_TRACK,
        SEL_HOLD
    } rims_sel_state_t;

endpackage
`default_nettype wire

/* File: rims_los_detect.sv */
// Loss-of-signal detector for one reference input
`timescale 1ns/1ps
`default_nettype none
`include "rims_regs.svh"

module rims_los_detect
(
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic       enable,
    input  wire logic       vcxoTick,
    input  wire logic [4:0] monitorDivider,
    input  wire logic [7:0] revalidateCount,
    input  wire logic       diffMode,
    input  wire logic       clkPin,
    input  wire logic       diffZeroPin,
    output logic            lossLive
);

    logic [1:0] clkSync;
    logic [1:0] zeroSync;
    logic       clkPrev;
    logic [4:0] divCnt;
    logic       edgeInPeriod;
    logic [1:0] missCnt;
    logic       edgeLoss;
    logic [7:0] validCnt;

    wire       edgeSeen      = clkSync[1] & ~clkPrev;
    wire [4:0] divLast       = (monitorDivider == 5'h00) ? 5'h00 : monitorDivider - 5'h01;
    // At-or-above keeps a shrunk divider from running the count the long way round
    wire       monTick       = vcxoTick & (divCnt >= divLast);
    wire       periodHadEdge = edgeInPeriod | edgeSeen;
    // Only missing edges count; a wrong but running frequency never trips this
    wire       missEvent     = monTick & ~periodHadEdge;
    wire       lossDeclare   = missEvent & (missCnt == `RIMS_MISS_LIMIT - 2'h1);
    wire       goodPeriod    = monTick & periodHadEdge;
    wire       revalDone     = goodPeriod & ((validCnt + 8'h01) >= revalidateCount);

    always_ff @(posedge sys_clk)
    begin
        clkSync  <= {clkSync[0], clkPin};
        zeroSync <= {zeroSync[0], diffZeroPin};
        clkPrev  <= clkSync[1];
    end

    // Monitor divider turns VCXO ticks into one tick per nominal input period
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b || !enable)
            divCnt <= 5'h00;
        else if (vcxoTick)
            divCnt <= monTick ? 5'h00 : divCnt + 5'h01;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b || !enable)
            edgeInPeriod <= 1'b0;
        else if (monTick)
            edgeInPeriod <= 1'b0;
        else if (edgeSeen)
            edgeInPeriod <= 1'b1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b || !enable)
            missCnt <= 2'h0;
        else if (goodPeriod)
            missCnt <= 2'h0;
        else if (missEvent && missCnt != `RIMS_MISS_LIMIT)
            missCnt <= missCnt + 2'h1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b || !enable)
            edgeLoss <= 1'b0;
        else if (lossDeclare)
            edgeLoss <= 1'b1;
        else if (edgeLoss && revalDone)
            edgeLoss <= 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b || !enable || !edgeLoss || missEvent)
            validCnt <= 8'h00;
        else if (goodPeriod && validCnt != 8'hFF)
            validCnt <= validCnt + 8'h01;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            lossLive <= 1'b0;
        else
            lossLive <= enable & (edgeLoss | (diffMode & zeroSync[1]));
    end

    property p_third_miss;
        @(posedge sys_clk) disable iff (!rst_b)
        (enable && lossDeclare) |=> edgeLoss ##1 lossLive;
    endproperty
    a_third_miss: assert property (p_third_miss) else $error("third missing edge not declared");

    property p_short_gap;
        @(posedge sys_clk) disable iff (!rst_b)
        (enable && !edgeLoss && missEvent && missCnt == 2'h0) |=> !edgeLoss;
    endproperty
    a_short_gap: assert property (p_short_gap) else $error("loss declared on one miss");

    property p_diff_zero;
        @(posedge sys_clk) disable iff (!rst_b)
        (enable && diffMode && zeroSync[1]) |=> lossLive;
    endproperty
    a_diff_zero: assert property (p_diff_zero) else $error("zero differential missed");

endmodule
`default_nettype wire

/* File: rims_ref_src.sv */
// Model of the VCXO and the two redundant reference clock sources
`timescale 1ns/1ps
`default_nettype none

module rims_ref_src
(
    input  wire logic       sys_clk,
    input  wire logic [1:0] runEn,
    input  wire logic [1:0] zeroDiff,
    output logic            vcxoClk,
    output logic [1:0]      refClkPin,
    output logic [1:0]      diffZeroPin
);
    logic [3:0] phase = 4'h0;

    always @(posedge sys_clk)
    begin
        phase <= phase + 4'h1;
    end

    // VCXO at a quarter of the sampling limit; references at VCXO/2
    assign vcxoClk     = phase[2];
    // A stopped source parks low, as a dead driver behind a pull-down would
    assign refClkPin   = runEn & {2{phase[3]}};
    assign diffZeroPin = zeroDiff;
endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the input monitor and selector
`timescale 1ns/1ps
`default_nettype none
`include "rims_regs.svh"

module testbench;
    logic        sys_clk;
    logic        rst_b;
    logic [7:0]  regAddr;
    logic [31:0] regWdata;
    logic        regWrite;
    logic        regRead;
    logic [31:0] regRdata;
    logic        vcxoClk;
    logic [1:0]  refClkPin;
    logic [1:0]  diffZeroPin;
    logic        select_pin;
    logic        pllRefSelect;
    logic        holdover_active_n;
    logic        irq_out_n;
    logic [1:0]  runEn;
    logic [1:0]  zeroDiff;
    int          failures;
    int          num_checks;

    rims_monitor_select rims_monitor_select_inst
    (
        .sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .vcxoClk(vcxoClk), .refClkPin(refClkPin),
        .diffZeroPin(diffZeroPin), .select_pin(select_pin),
        .pllRefSelect(pllRefSelect), .holdover_active_n(holdover_active_n),
        .irq_out_n(irq_out_n)
    );

    rims_ref_src rims_ref_src_inst
    (
        .sys_clk(sys_clk), .runEn(runEn), .zeroDiff(zeroDiff),
        .vcxoClk(vcxoClk), .refClkPin(refClkPin), .diffZeroPin(diffZeroPin)
    );

    // ==========================================
    // Access and compare tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), e & m, regRdata & m);
    endtask

    task automatic st(input logic [7:0] m, input logic [7:0] e);
        rd(`RIMS_ADDR_STATUS, {24'h00_0000, m}, {24'h00_0000, e});
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic pins(input logic s, input logic h, input logic q);
        #1;
        chk("pllRefSelect", {31'h0, s}, {31'h0, pllRefSelect});
        chk("holdover_active_n", {31'h0, h}, {31'h0, holdover_active_n});
        chk("irq_out_n", {31'h0, q}, {31'h0, irq_out_n});
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    initial
    begin
        wt(20000);
        failures++;
        $display("Watchdog expired");
        wrap_up();
    end

    // ==========================================
    // Tests
    initial
    begin
        failures = 0;
        num_checks = 0;
        rst_b = 1'b0;
        regAddr = 8'h00;
        regWdata = 32'h0000_0000;
        regWrite = 1'b0;
        regRead = 1'b0;
        select_pin = 1'b0;
        runEn = 2'b11;
        zeroDiff = 2'b00;
        wt(4);
        rst_b <= 1'b1;
        rd(`RIMS_ADDR_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
        rd(`RIMS_ADDR_MONDIV, 32'hFFFF_FFFF, 32'h0000_0101);
        rd(`RIMS_ADDR_REVAL, 32'hFFFF_FFFF, 32'h0000_0004);
        rd(`RIMS_ADDR_HOLDOFF, 32'hFFFF_FFFF, 32'h0000_0010);
        rd(`RIMS_ADDR_PRESCALE, 32'hFFFF_FFFF, 32'h0000_0001);
        rd(`RIMS_ADDR_MASK, 32'hFFFF_FFFF, 32'h0000_0003);
        rd(8'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
        st(8'h3F, 8'h10);
        $display("test reset values done");
        // Divider 2 matches the model's reference rate
        wr(`RIMS_ADDR_MONDIV, 32'h0000_0202);
        wr(`RIMS_ADDR_HOLDOFF, 32'h0000_0003);
        wr(`RIMS_ADDR_STATUS, 32'h0000_000C);
        runEn <= 2'b01;
        wt(16);
        st(8'h0F, 8'h00);
        wt(100);
        st(8'h0F, 8'h0A);
        pins(1'b0, 1'b1, 1'b0);
        runEn <= 2'b11;
        wt(30);
        st(8'h03, 8'h02);
        wt(150);
        st(8'h0F, 8'h08);
        pins(1'b0, 1'b1, 1'b0);
        wr(`RIMS_ADDR_STATUS, 32'h0000_0008);
        st(8'h0F, 8'h00);
        pins(1'b0, 1'b1, 1'b1);
        wr(`RIMS_ADDR_MASK, 32'h0000_0001);
        runEn <= 2'b01;
        wt(120);
        st(8'h0F, 8'h0A);
        pins(1'b0, 1'b1, 1'b1);
        runEn <= 2'b11;
        wt(150);
        wr(`RIMS_ADDR_STATUS, 32'h0000_000C);
        wr(`RIMS_ADDR_MASK, 32'h0000_0003);
        $display("test loss and recovery done");
        // Only input 0 is in differential mode, so input 1 must ignore its flag
        wr(`RIMS_ADDR_CTRL, 32'h0000_0040);
        zeroDiff <= 2'b11;
        wt(8);
        st(8'h03, 8'h01);
        zeroDiff <= 2'b00;
        wr(`RIMS_ADDR_CTRL, 32'h0000_0000);
        wt(150);
        wr(`RIMS_ADDR_STATUS, 32'h0000_000C);
        // Bypass goes with manual selection
        wr(`RIMS_ADDR_CTRL, 32'h0000_0003);
        runEn <= 2'b10;
        wt(100);
        st(8'h03, 8'h00);
        runEn <= 2'b11;
        wr(`RIMS_ADDR_CTRL, 32'h0000_0000);
        wt(150);
        wr(`RIMS_ADDR_STATUS, 32'h0000_000C);
        $display("test differential and bypass done");
        // First switch lands on a dead input
        runEn <= 2'b01;
        wt(100);
        for (int p = 1; p <= 2; p++)
        begin
            wr(`RIMS_ADDR_PRESCALE, p);
            select_pin <= p[0];
            wt(14 * p);
            pins(~p[0], 1'b0, 1'b0);
            wt(50 * p);
            pins(p[0], 1'b1, 1'b0);
        end
        runEn <= 2'b10;
        wt(100);
        pins(1'b0, 1'b1, 1'b0);
        st(8'h61, 8'h41);
        runEn <= 2'b11;
        $display("test holdover control done");
        for (int m = 0; m < 4; m++)
        begin
            wr(`RIMS_ADDR_CTRL, {26'h0, ~m[0], 1'b1, m[1:0], 2'b10});
            select_pin <= m[0];
            wt(3);
            pins(~m[0], 1'b1, 1'b0);
        end
        runEn <= 2'b10;
        wt(100);
        pins(1'b0, 1'b1, 1'b0);
        st(8'h61, 8'h41);
        // Plain manual mode reports no reference loss even with the primary dead
        wr(`RIMS_ADDR_CTRL, 32'h0000_0012);
        st(8'h61, 8'h01);
        $display("test manual modes done");
        wrap_up();
    end
endmodule
`default_nettype wire
